// [include/ccrs_pkg.sv]
// Constants and types for the processor clock, ready and reset block.
// Assumes a single 125 MHz ref_clk and Avalon-MM register access.
// Function
// - Reset output is inverted request, clocked
// - Source select: crystal low, external high
// - Processor clock is source divided by three
// - Peripheral clock is processor clock halved
// - Oscillator output always follows the crystal
// - Sync mode low double, high single
// - Double mode: high passes both stages
// - Double mode: low bypasses first stage
// - Single mode: second stage only, falling edge
// - Each ready honoured only while qualified
// - Phase sync holds divider, clock high
// - Peripheral clock has 50% duty
`default_nettype none

package ccrs_pkg;

  localparam int unsigned CCRS_ADDR_W = 4;
  localparam int unsigned CCRS_DATA_W = 32;

  // Byte addresses of the two registers
  localparam logic [3:0] CCRS_CTRL_ADDR = 4'h0;
  localparam logic [3:0] CCRS_STAT_ADDR = 4'h4;

  // Control register fields
  localparam int unsigned CCRS_CTRL_SRC_BIT = 0;
  localparam int unsigned CCRS_CTRL_MODE_BIT = 1;
  localparam int unsigned CCRS_CTRL_PSYNC_BIT = 2;
  // Sync mode resets high, as the pulled-up pin would read
  localparam logic [2:0] CCRS_CTRL_RESET = 3'h2;

  // Status register fields
  localparam int unsigned CCRS_STAT_PROC_BIT = 0;
  localparam int unsigned CCRS_STAT_PERIPH_BIT = 1;
  localparam int unsigned CCRS_STAT_READY_BIT = 2;
  localparam int unsigned CCRS_STAT_RESET_BIT = 3;
  localparam int unsigned CCRS_STAT_FIRST_BIT = 4;

  // Divider phases
  localparam logic [1:0] CCRS_DIV_HIGH = 2'h0;
  localparam logic [1:0] CCRS_DIV_LAST = 2'h2;

  typedef struct packed {
    logic [1:0] bus_ready_in;
    logic [1:0] ready_qualify_n;
  } ccrs_ready_s;

endpackage : ccrs_pkg

`default_nettype wire

// [rtl/ccrs_clock_ready_reset.sv]
// Processor clock divider, peripheral clock, ready and reset synchroniser.
// Source clock pins are sampled as ordinary inputs of ref_clk, so they must
// run well below half the ref_clk rate.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`default_nettype none

module ccrs_clock_ready_reset
  import ccrs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [CCRS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [CCRS_DATA_W-1:0] avs_writedata,
  output logic [CCRS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic crystal_pin_a,
  output logic crystal_pin_b,
  input wire logic external_clock_in,
  input wire logic reset_request_n,
  input wire ccrs_ready_s ready_in,
  output logic oscillator_out,
  output logic proc_clock_out,
  output logic peripheral_clock,
  output logic ready_out,
  output logic system_reset_out
);

  function automatic logic ready_level(input ccrs_ready_s r);
    ready_level = (r.bus_ready_in[0] & ~r.ready_qualify_n[0])
                | (r.bus_ready_in[1] & ~r.ready_qualify_n[1]);
  endfunction : ready_level

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [2:0] ctrl_q, ctrl_d;
  logic wait_q, wait_d;
  logic [CCRS_DATA_W-1:0] rdata_q, rdata_d;
  logic clock_source_select, ready_sync_mode_n, clock_phase_sync;
  logic first_stage_flop_q, first_stage_flop_d;
  logic src_q, src_d, div_rise;
  logic [1:0] div_q, div_d;
  logic proc_q, proc_d, periph_q, periph_d;
  logic ready_q, ready_d, rst_out_q, rst_out_d;
  logic osc_q, xb_q;
  logic proc_rise_ev, proc_fall_ev, rdy_lvl;

  assign clock_source_select = ctrl_q[CCRS_CTRL_SRC_BIT];
  assign ready_sync_mode_n = ctrl_q[CCRS_CTRL_MODE_BIT];
  assign clock_phase_sync = ctrl_q[CCRS_CTRL_PSYNC_BIT];

  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    // One wait cycle, then a single cycle with waitrequest low
    wait_d = ~((avs_read | avs_write) & wait_q);
    if (wait_q && avs_read)
    begin
      if (avs_address == CCRS_CTRL_ADDR)
      begin
        rdata_d = {29'h0000000, ctrl_q};
      end
      else if (avs_address == CCRS_STAT_ADDR)
      begin
        rdata_d = {27'h0000000, first_stage_flop_q, rst_out_q, ready_q,
                   periph_q, proc_q};
      end
      else
      begin
        rdata_d = 32'h00000000;
      end
    end
    if (!wait_q && avs_write && avs_byteenable[0])
    begin
      if (avs_address == CCRS_CTRL_ADDR)
      begin
        ctrl_d = avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CCRS_CTRL_RESET;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock divider

  always_comb
  begin
    src_d = clock_source_select ? external_clock_in : crystal_pin_a;
    div_rise = src_d & ~src_q;
    div_d = div_q;
    proc_d = proc_q;
    if (clock_phase_sync)
    begin
      div_d = CCRS_DIV_HIGH;
      proc_d = 1'b1;
    end
    else if (div_rise)
    begin
      div_d = (div_q == CCRS_DIV_LAST) ? CCRS_DIV_HIGH : div_q + 2'h1;
      proc_d = (div_d == CCRS_DIV_HIGH);
    end
    proc_rise_ev = proc_d & ~proc_q;
    proc_fall_ev = ~proc_d & proc_q;
    rdy_lvl = ready_level(ready_in);
    periph_d = periph_q;
    if (clock_phase_sync)
    begin
      periph_d = 1'b1;
    end
    else if (proc_fall_ev)
    begin
      periph_d = ~periph_q;
    end
    first_stage_flop_d = proc_rise_ev ? rdy_lvl : first_stage_flop_q;
    ready_d = ready_q;
    rst_out_d = rst_out_q;
    if (proc_fall_ev)
    begin
      // Low level skips the first stage, so ready drops fast
      ready_d = ready_sync_mode_n ? rdy_lvl
                                  : rdy_lvl & first_stage_flop_q;
      rst_out_d = ~reset_request_n;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      src_q <= 1'b0;
      div_q <= CCRS_DIV_HIGH;
      proc_q <= 1'b1;
      periph_q <= 1'b1;
      first_stage_flop_q <= 1'b0;
      ready_q <= 1'b0;
      rst_out_q <= 1'b1;
      osc_q <= 1'b0;
      xb_q <= 1'b1;
    end
    else
    begin
      src_q <= src_d;
      div_q <= div_d;
      proc_q <= proc_d;
      periph_q <= periph_d;
      first_stage_flop_q <= first_stage_flop_d;
      ready_q <= ready_d;
      rst_out_q <= rst_out_d;
      osc_q <= crystal_pin_a;
      xb_q <= ~crystal_pin_a;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign crystal_pin_b = xb_q;
  assign oscillator_out = osc_q;
  assign proc_clock_out = proc_q;
  assign peripheral_clock = periph_q;
  assign ready_out = ready_q;
  assign system_reset_out = rst_out_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_rst_follow;
    proc_fall_ev |=> system_reset_out == !$past(reset_request_n);
  endproperty
  a_rst_follow: assert property (p_rst_follow)
    else $error("reset output not inverse of request");

  property p_src_sel;
    (!clock_source_select && !clock_phase_sync && $past(src_q) == src_q
      && src_q != crystal_pin_a) |=> $changed(src_q);
  endproperty
  a_src_sel: assert property (p_src_sel)
    else $error("crystal not followed as source");

  property p_div3;
    $rose(proc_q) && !$past(clock_phase_sync) |-> $past(div_q) == 2'h2;
  endproperty
  a_div3: assert property (p_div3)
    else $error("processor clock not divide by three");

  property p_periph;
    $fell(proc_q) && !$past(clock_phase_sync) |-> $changed(periph_q);
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral clock missed a toggle");

  property p_osc;
    ##1 oscillator_out == $past(crystal_pin_a);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator output not following crystal");

  property p_dbl_high;
    $rose(ready_out) && !$past(ready_sync_mode_n) |-> $past(first_stage_flop_q);
  endproperty
  a_dbl_high: assert property (p_dbl_high)
    else $error("ready rose without first stage");

  property p_dbl_low;
    proc_fall_ev && !rdy_lvl |=> !ready_out;
  endproperty
  a_dbl_low: assert property (p_dbl_low)
    else $error("ready not dropped at falling edge");

  property p_single;
    proc_fall_ev && ready_sync_mode_n |=> ready_out == $past(rdy_lvl);
  endproperty
  a_single: assert property (p_single)
    else $error("single sync ready mismatch");

  property p_qualify;
    proc_fall_ev && (&ready_in.ready_qualify_n) |=> !ready_out;
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("unqualified ready honoured");

  property p_psync;
    clock_phase_sync |=> proc_q && div_q == 2'h0 && periph_q;
  endproperty
  a_psync: assert property (p_psync)
    else $error("phase sync did not hold clock high");

  c_ready_dbl: cover property (!ready_sync_mode_n && $rose(ready_out));
  c_ready_single: cover property (ready_sync_mode_n && $fell(ready_out));
  c_ext_clock: cover property (clock_source_select && $rose(proc_q));
  c_reg_write: cover property (!wait_q && avs_write);

endmodule : ccrs_clock_ready_reset

`default_nettype wire

// [dv/ccrs_far_side.sv]
// Far-side model: crystal, external source clock and reset requester.
// Assumes ref_clk runs free and nrst is the bench's reset.
`default_nettype none
module ccrs_far_side #(
  parameter int HOLD = 40
)(
  input wire logic ref_clk,
  input wire logic nrst,
  output logic crystal_pin_a,
  output logic external_clock_in,
  output logic reset_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // Sources far below half ref_clk so the sampler sees every edge
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      n <= 0;
      crystal_pin_a <= 1'b0;
      external_clock_in <= 1'b0;
      reset_request_n <= 1'b0;
    end
    else
    begin
      n <= n + 1;
      crystal_pin_a <= ((n / 3) % 2) == 1;
      external_clock_in <= ((n / 4) % 2) == 1;
      reset_request_n <= n >= HOLD;
    end
endmodule : ccrs_far_side
`default_nettype wire

// [dv/ccrs_clock_ready_reset_bench.sv]
// Bench for the clock, ready and reset block over its Avalon port.
// Assumes the far-side model supplies source clocks and reset request.
`default_nettype none
module ccrs_clock_ready_reset_bench import ccrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [CCRS_ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [CCRS_DATA_W-1:0] wdat = '0;
  logic [CCRS_DATA_W-1:0] rdat;
  logic wreq, xa, xb, xe, rqn, osc, prc, per, rdy, rso;
  ccrs_ready_s rin = 4'h3;
  logic [3:0] tv [5] = '{4'h6, 4'h5, 4'h9, 4'hA, 4'hC};
  logic [4:0] ev = 5'h15;
  logic [31:0] v;
  int errors = 0;
  int n_tests = 0;
  int c;
  always #4 ref_clk = ~ref_clk;
  ccrs_far_side far (.ref_clk(ref_clk), .nrst(nrst), .crystal_pin_a(xa),
    .external_clock_in(xe), .reset_request_n(rqn));
  ccrs_clock_ready_reset dut (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .crystal_pin_a(xa), .crystal_pin_b(xb), .external_clock_in(xe),
    .reset_request_n(rqn), .ready_in(rin), .oscillator_out(osc),
    .proc_clock_out(prc), .peripheral_clock(per), .ready_out(rdy),
    .system_reset_out(rso));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do
      @(posedge ref_clk);
    while (wreq !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  function automatic logic sig(input int s);
    return s == 0 ? prc : s == 1 ? per : osc;
  endfunction : sig
  task automatic till(input int s, input logic l, output int k);
    k = 0;
    do
    begin
      tick();
      k++;
    end
    while (sig(s) !== l);
  endtask : till
  task automatic cyc;
    till(0, 1'b1, c);
    till(0, 1'b0, c);
  endtask : cyc
  task automatic setr(input logic [3:0] x);
    @(posedge ref_clk);
    rin <= x;
  endtask : setr
  // High span is counted first, so period is high plus low
  task automatic measure(input int s, input int ep, input int eh);
    int h;
    int l;
    till(s, 1'b0, h);
    till(s, 1'b1, h);
    till(s, 1'b0, h);
    till(s, 1'b1, l);
    chk(h + l, ep);
    chk(h, eh);
  endtask : measure
  task automatic conclude;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(1'b0, CCRS_CTRL_ADDR, 32'h0);
    chk(v, {29'h0, CCRS_CTRL_RESET});
    chk(rso, 1'b1);
    bus(1'b0, 4'h8, 32'h0);
    chk(v, 32'h0);
    do
      tick();
    while (rqn !== 1'b1);
    cyc();
    chk(rso, 1'b0);
    measure(0, 18, 6);
    measure(1, 36, 18);
    measure(2, 6, 3);
    chk(xb, 1'b0);
    bus(1'b1, CCRS_CTRL_ADDR, 32'h3);
    measure(0, 24, 8);
    measure(2, 6, 3);
    chk(xb, 1'b0);
    bus(1'b1, CCRS_CTRL_ADDR, 32'h6);
    repeat (12) tick();
    chk({prc, per}, 2'h3);
    bus(1'b0, CCRS_STAT_ADDR, 32'h0);
    chk(v[1:0], 2'h3);
    bus(1'b1, CCRS_CTRL_ADDR, 32'h2);
    // Writes without the low byte lane, or to status, must be dropped
    be <= 4'hE;
    measure(0, 18, 6);
    bus(1'b1, CCRS_CTRL_ADDR, 32'h5);
    be <= 4'hF;
    bus(1'b1, CCRS_STAT_ADDR, 32'h5);
    bus(1'b0, CCRS_CTRL_ADDR, 32'h0);
    chk(v, 32'h2);
    // Ready raised while proc is high: only single mode passes it at once
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, CCRS_CTRL_ADDR, m == 1 ? 32'h2 : 32'h0);
      setr(4'h3);
      cyc();
      cyc();
      till(0, 1'b1, c);
      setr(4'h6);
      till(0, 1'b0, c);
      chk(rdy, m[0]);
      cyc();
      chk(rdy, 1'b1);
      till(0, 1'b1, c);
      setr(4'h3);
      till(0, 1'b0, c);
      chk(rdy, 1'b0);
    end
    for (int i = 0; i < 5; i++)
    begin
      setr(tv[i]);
      cyc();
      cyc();
      chk(rdy, ev[i]);
    end
    conclude();
  end
endmodule : ccrs_clock_ready_reset_bench
`default_nettype wire
